// >>> core_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "core_consts.vh"
module core_checker (
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic [15:0] prog_addr_out,
   input wire logic [21:0] prog_data_in,
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_we_in,
   input wire logic [7:0]  wb_adr_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic        wb_ack_out,
   input wire logic        halted_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic [1:0] up_q;
   // outputs read zero just after reset, so core checks wait a few edges
   always_ff @(posedge clk_in or negedge rst_n_in)
      if (!rst_n_in)
         up_q <= 2'h0;
      else if (up_q != 2'h3)
         up_q <= up_q + 2'h1;
   wire logic       run_ok = (up_q == 2'h3) && !halted_out;
   wire logic [5:0] op     = prog_data_in[21:16];

   a_ack_next_edge: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("no ack after request");
   a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   a_read_upper_zero: assert property (wb_ack_out && !wb_we_in |-> wb_dat_out[31:8] == 24'h0)
      else $error("read data wider than a byte");
   a_unmapped_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in[7] |-> wb_dat_out == 32'h0)
      else $error("unmapped read not zero");
   a_movi_steps: assert property (run_ok && $past(run_ok) && op == `OP_MOVI
      |=> prog_addr_out == $past(prog_addr_out) + 16'h1) else $error("program counter did not step");
   a_jmp_target: assert property (run_ok && $past(run_ok) && op == `OP_JMP
      |=> prog_addr_out == $past(prog_data_in[15:0])) else $error("jump missed its target");
   a_halt_stops: assert property (run_ok && op == `OP_HALT |-> ##[1:2] halted_out)
      else $error("halt did not stop core");
   a_halt_holds_pc: assert property (halted_out && $past(halted_out) |-> $stable(prog_addr_out))
      else $error("program counter moved while stopped");
endmodule // core_checker
bind risc_core core_checker core_checker_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .prog_addr_out(prog_addr_out), .prog_data_in(prog_data_in), .wb_cyc_in(wb_cyc_in),
   .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
   .wb_ack_out(wb_ack_out), .halted_out(halted_out));
`default_nettype wire

// >>> core_consts.vh
`ifndef CORE_CONSTS_VH
`define CORE_CONSTS_VH
// wishbone register offsets (byte addresses)
`define REG_CTRL_OFF      8'h00
`define REG_STATUS_OFF    8'h04
`define REG_PC_OFF        8'h08
`define REG_EVT_OFF       8'h0c
`define REG_FILE_OFF      8'h40
// control register fields
`define CTRL_RUN_BIT      0
`define CTRL_RESET_VAL    8'h00
// status register field positions
`define ST_IE2_BIT        0
`define ST_IE1_BIT        1
`define ST_GIE_BIT        2
`define ST_IN2_BIT        3
`define ST_IN1_BIT        4
`define ST_IN0_BIT        5
`define ST_EV1_BIT        6
`define ST_EV0_BIT        7
`define ST_RESET_VAL      8'h00
// register indices in the file
`define R_A               4'hf
`define R_STAT            4'he
`define R_IPL             4'hd
`define R_IPH             4'hc
// opcode field
`define OP_NOP            6'h00
`define OP_MOVI           6'h01
`define OP_MOV            6'h02
`define OP_ADD            6'h03
`define OP_SUB            6'h04
`define OP_AND            6'h05
`define OP_OR             6'h06
`define OP_XOR            6'h07
`define OP_MUL            6'h08
`define OP_JMP            6'h09
`define OP_JZ             6'h0a
`define OP_JNZ            6'h0b
`define OP_CALL           6'h0c
`define OP_RET            6'h0d
`define OP_RETI           6'h0e
`define OP_HALT           6'h0f
`define OP_JIND           6'h10
`define OP_INC            6'h11
`define OP_DEC            6'h12
`define OP_SHL            6'h13
`define OP_SHR            6'h14
`define OP_CMP            6'h15
`define OP_LAST           6'h22
`define IRQ_VEC2          16'h0008
`define IRQ_VEC1          16'h0004
`define IRQ_VEC0          16'h0002
`define PC_RESET          16'h0000
`endif

// >>> prog_rom.sv
`timescale 1ns/1ps
`default_nettype none
`include "core_consts.vh"
// program store, answers in the same cycle; unused words fetch as no-op
module prog_rom (
   // fetch side
   input  wire logic [15:0] addr_in,
   input  wire logic [7:0]  rnd_in,
   output logic      [21:0] data_out
);
   // mode 1 takes the low byte as an immediate operand
   function automatic logic [21:0] im(input logic [5:0] op, input logic [3:0] rd, input logic [7:0] v);
      im = {op, 3'h1, rd, 1'b0, v};
   endfunction
   function automatic logic [21:0] mv(input logic [3:0] rd, input logic [7:0] v);
      mv = im(`OP_MOVI, rd, v);
   endfunction
   function automatic logic [21:0] jp(input logic [5:0] op, input logic [15:0] a);
      jp = {op, a};
   endfunction
   always_comb
   begin
      case (addr_in)
         16'h0000: data_out = jp(`OP_JMP, 16'h0010);
         16'h0002: data_out = jp(`OP_JMP, 16'h0020);
         16'h0008: data_out = mv(`R_STAT, 8'h01);
         16'h0009: data_out = mv(4'h3, 8'h33);
         16'h000a: data_out = jp(`OP_RETI, 16'h0000);
         16'h0010: data_out = mv(4'h1, rnd_in);
         16'h0011: data_out = jp(`OP_HALT, 16'h0000);
         16'h0012: data_out = mv(`R_STAT, 8'h05);
         16'h0013: data_out = mv(4'h2, 8'ha5);
         16'h0014: data_out = jp(`OP_HALT, 16'h0000);
         16'h0015: data_out = mv(4'h4, 8'h44);
         16'h0016: data_out = jp(`OP_HALT, 16'h0000);
         16'h0020: data_out = mv(`R_STAT, 8'h00);
         16'h0021: data_out = jp(`OP_JMP, 16'h0024);
         16'h0024: data_out = mv(4'h5, 8'h55);
         16'h0025: data_out = mv(4'h6, 8'h0d);
         16'h0026: data_out = im(`OP_MUL, 4'h6, 8'h0b);
         16'h0027: data_out = jp(`OP_CALL, 16'h0030);
         16'h0028: data_out = mv(`R_IPH, 8'h00);
         16'h0029: data_out = mv(`R_IPL, 8'h38);
         16'h002a: data_out = jp(`OP_JIND, 16'h0000);
         16'h0030: data_out = mv(4'h7, 8'h77);
         16'h0031: data_out = jp(`OP_RET, 16'h0000);
         16'h0038: data_out = jp(`OP_HALT, 16'h0000);
         default:  data_out = 22'h000000;
      endcase
   end
endmodule // prog_rom
`default_nettype wire

// >>> return_stack.v
`timescale 1ns/1ps
`default_nettype none
// hardware stack of return addresses; overflow wraps silently
module return_stack #(
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // clock and reset
   input  wire          clk_in,
   input  wire          rst_n_in,
   // push and pop
   input  wire          push_in,
   input  wire          pop_in,
   input  wire [15:0]   push_addr_in,
   output wire [15:0]   top_addr_out
);
   reg [15:0]   mem [0:DEPTH-1];
   reg [AW-1:0] sp_q;
   wire [AW-1:0] top_idx;
   assign top_idx      = sp_q - {{(AW-1){1'b0}}, 1'b1};
   assign top_addr_out = mem[top_idx];
   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         sp_q <= {AW{1'b0}};
      else if (push_in)
         sp_q <= sp_q + {{(AW-1){1'b0}}, 1'b1};
      else if (pop_in)
         sp_q <= top_idx;
   end
   always @(posedge clk_in)
   begin
      if (push_in)
         mem[sp_q] <= push_addr_in;
   end
endmodule // return_stack
`default_nettype wire

// >>> risc_core.v
// Notes on behaviour
// - every instruction, jumps and 8x8 multiply included, finishes in one clock.
// - decode 22 instruction codes (0x00 to 0x15) from a fixed 22-bit word, 8 addressing modes.
// - sixteen internal 8-bit registers.
// - register pairs join into 16-bit operands for wide instructions.
// - one status register holds interrupt enables and interrupt and event requests.
// - after halt the core stays stopped until an enabled interrupt or an event is pending.
// - interrupt wake branches to handler; event wake resumes after the halt.
// - a 16-bit program counter holds the address of the instruction being executed.
// - calls and interrupts push the return address; returns restore it.
// - levels 2 and 1 have own enables plus global enable; both needed.
// - three interrupt request bits for low, mid, high sources; software clears.
// - two event request bits for low and high sources; software clears.
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "core_consts.vh"
module risc_core #(
   parameter STACK_DEPTH = 8
) (
   // clock and reset
   input  wire          clk_in,
   input  wire          rst_n_in,
   // program memory
   output reg  [15:0]   prog_addr_out,
   input  wire [21:0]   prog_data_in,
   // request sources (asynchronous)
   input  wire          irq_low_in,
   input  wire          irq_mid_in,
   input  wire          irq_high_in,
   input  wire          evt_low_in,
   input  wire          evt_high_in,
   // wishbone slave
   input  wire          wb_cyc_in,
   input  wire          wb_stb_in,
   input  wire          wb_we_in,
   input  wire [7:0]    wb_adr_in,
   input  wire [31:0]   wb_dat_in,
   input  wire [3:0]    wb_sel_in,
   output reg  [31:0]   wb_dat_out,
   output reg           wb_ack_out,
   // core state
   output reg           halted_out
);
   localparam ST_RUN  = 2'b00;
   localparam ST_HALT = 2'b01;
   localparam ST_STOP = 2'b10;

   reg [7:0]  rf_q [0:15];
   reg [15:0] instruction_pointer_q;
   reg [1:0]  state_q;
   reg [7:0]  ctrl_q;
   reg        zero_q;
   reg [4:0]  src_s1_q, src_s2_q, src_prev_q;
   integer    i;

   // 16-bit pair: even register is high byte
   function [15:0] pair;
      input [2:0]   idx;
      input [127:0] flat;
      reg   [6:0]   base;
      begin
         base = {idx, 4'h0};
         pair = {flat[base +: 8], flat[base + 7'd8 +: 8]};
      end
   endfunction

   wire [127:0] rf_flat;
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1)
      begin : g_flat
         assign rf_flat[g*8 +: 8] = rf_q[g];
      end
   endgenerate

   wire [7:0]  stat = rf_q[`R_STAT];
   // field split: op[21:16] mode[15:13] dst[12:9] src[8:5] ... imm/addr in low 16
   wire [5:0]  op   = prog_data_in[21:16];
   wire [2:0]  mode = prog_data_in[15:13];
   wire [3:0]  rd   = prog_data_in[12:9];
   wire [3:0]  rs   = prog_data_in[8:5];
   wire [7:0]  imm  = prog_data_in[7:0];
   wire [15:0] jaddr = prog_data_in[15:0];

   wire [15:0] pair_rs = pair(rs[3:1], rf_flat);

   // eight addressing modes choose the second operand
   reg [7:0] opb;
   always @*
   begin
      case (mode)
         3'd0:    opb = rf_q[rs];
         3'd1:    opb = imm;
         3'd2:    opb = rf_q[`R_A];
         3'd3:    opb = pair_rs[15:8];
         3'd4:    opb = pair_rs[7:0];
         3'd5:    opb = ~rf_q[rs];
         3'd6:    opb = {4'h0, rs};
         default: opb = 8'h00;
      endcase
   end

   wire [15:0] product = rf_q[rd] * opb;
   wire [15:0] pc_next = instruction_pointer_q + 16'h0001;

   // interrupt acceptance: level 0 is high priority, unmasked by level enable
   wire global_irq_enable = stat[`ST_GIE_BIT];
   wire take0 = global_irq_enable & stat[`ST_IN0_BIT];
   wire take1 = global_irq_enable & stat[`ST_IE1_BIT] & stat[`ST_IN1_BIT];
   wire take2 = global_irq_enable & stat[`ST_IE2_BIT] & stat[`ST_IN2_BIT];
   wire take_irq = take0 | take1 | take2;
   wire [15:0] vec = take0 ? `IRQ_VEC0 : (take1 ? `IRQ_VEC1 : `IRQ_VEC2);
   wire evt_pend = stat[`ST_EV0_BIT] | stat[`ST_EV1_BIT];
   wire running = ctrl_q[`CTRL_RUN_BIT];

   // stack control
   reg        push, pop;
   reg [15:0] push_addr;
   wire [15:0] ret_addr;
   return_stack #(.DEPTH(STACK_DEPTH), .AW(3)) u_stack (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n_in),
      .push_in      (push),
      .pop_in       (pop),
      .push_addr_in (push_addr),
      .top_addr_out (ret_addr)
   );

   // synchronisers for request pins
   wire [4:0] src_raw = {evt_high_in, evt_low_in, irq_high_in, irq_mid_in, irq_low_in};
   wire [4:0] src_rise = src_s2_q & ~src_prev_q;

   wire wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   wire wb_wr  = wb_req & wb_we_in & wb_sel_in[0];

   reg [15:0] pc_d;
   reg        wr_en;
   reg [7:0]  wr_val;
   reg        z_d;
   reg [1:0]  state_d;
   always @*
   begin
      pc_d = instruction_pointer_q;
      wr_en = 1'b0;
      wr_val = 8'h00;
      z_d = zero_q;
      state_d = state_q;
      push = 1'b0;
      pop = 1'b0;
      push_addr = pc_next;
      case (state_q)
         ST_RUN:
         begin
            if (!running)
               state_d = ST_STOP;
            else if (take_irq)
            begin
               // current instruction is deferred; return to it
               push = 1'b1;
               push_addr = instruction_pointer_q;
               pc_d = vec;
            end
            else
            begin
               pc_d = pc_next;
               case (op)
                  `OP_NOP: ;
                  `OP_MOVI, `OP_MOV: begin wr_en = 1'b1; wr_val = opb; end
                  `OP_ADD: begin wr_en = 1'b1; wr_val = rf_q[rd] + opb; end
                  `OP_SUB, `OP_CMP: begin wr_en = (op == `OP_SUB); wr_val = rf_q[rd] - opb; end
                  `OP_AND: begin wr_en = 1'b1; wr_val = rf_q[rd] & opb; end
                  `OP_OR:  begin wr_en = 1'b1; wr_val = rf_q[rd] | opb; end
                  `OP_XOR: begin wr_en = 1'b1; wr_val = rf_q[rd] ^ opb; end
                  `OP_INC: begin wr_en = 1'b1; wr_val = rf_q[rd] + 8'h01; end
                  `OP_DEC: begin wr_en = 1'b1; wr_val = rf_q[rd] - 8'h01; end
                  `OP_SHL: begin wr_en = 1'b1; wr_val = {rf_q[rd][6:0], 1'b0}; end
                  `OP_SHR: begin wr_en = 1'b1; wr_val = {1'b0, rf_q[rd][7:1]}; end
                  `OP_MUL: begin wr_en = 1'b1; wr_val = product[7:0]; end
                  `OP_JMP: pc_d = jaddr;
                  `OP_JZ:  if (zero_q) pc_d = jaddr;
                  `OP_JNZ: if (!zero_q) pc_d = jaddr;
                  `OP_JIND: pc_d = pair(3'd6, rf_flat);
                  `OP_CALL: begin push = 1'b1; pc_d = jaddr; end
                  `OP_RET, `OP_RETI: begin pop = 1'b1; pc_d = ret_addr; end
                  `OP_HALT: state_d = ST_HALT;
                  default: ;
               endcase
               if (wr_en || op == `OP_CMP)
                  z_d = (wr_val == 8'h00);
            end
         end
         ST_HALT:
         begin
            if (take_irq)
            begin
               // branch to handler, resume after halt on return
               push = 1'b1;
               push_addr = instruction_pointer_q;
               pc_d = vec;
               state_d = ST_RUN;
            end
            else if (evt_pend)
               state_d = ST_RUN;
         end
         ST_STOP:
            if (running)
               state_d = ST_RUN;
         default: state_d = ST_RUN;
      endcase
   end

   always @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         src_s1_q <= 5'h00;
         src_s2_q <= 5'h00;
         src_prev_q <= 5'h00;
         instruction_pointer_q <= `PC_RESET;
         prog_addr_out <= `PC_RESET;
         state_q <= ST_STOP;
         ctrl_q <= `CTRL_RESET_VAL;
         zero_q <= 1'b0;
         halted_out <= 1'b0;
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
         for (i = 0; i < 16; i = i + 1)
            rf_q[i] <= 8'h00;
      end
      else
      begin
         src_s1_q <= src_raw;
         src_s2_q <= src_s1_q;
         src_prev_q <= src_s2_q;
         instruction_pointer_q <= pc_d;
         prog_addr_out <= pc_d;
         state_q <= state_d;
         zero_q <= z_d;
         halted_out <= (state_d != ST_RUN);
         if (wr_en)
            rf_q[rd] <= wr_val;
         if (push && state_q != ST_HALT)
         begin
            // interrupt entry clears global enable
            if (take_irq)
               rf_q[`R_STAT][`ST_GIE_BIT] <= 1'b0;
         end
         if (state_q == ST_HALT && take_irq)
            rf_q[`R_STAT][`ST_GIE_BIT] <= 1'b0;
         if (state_q == ST_RUN && running && !take_irq && op == `OP_RETI)
            rf_q[`R_STAT][`ST_GIE_BIT] <= 1'b1;
         if (wb_wr && wb_adr_in == `REG_CTRL_OFF)
            ctrl_q <= wb_dat_in[7:0];
         if (wb_wr && wb_adr_in == `REG_STATUS_OFF)
            rf_q[`R_STAT] <= wb_dat_in[7:0];
         if (wb_wr && wb_adr_in[7:6] == 2'b01)
            rf_q[wb_adr_in[5:2]] <= wb_dat_in[7:0];
         // request bits: a new edge wins over a clear in the same cycle
         if (src_rise[0]) rf_q[`R_STAT][`ST_IN2_BIT] <= 1'b1;
         if (src_rise[1]) rf_q[`R_STAT][`ST_IN1_BIT] <= 1'b1;
         if (src_rise[2]) rf_q[`R_STAT][`ST_IN0_BIT] <= 1'b1;
         if (src_rise[3]) rf_q[`R_STAT][`ST_EV1_BIT] <= 1'b1;
         if (src_rise[4]) rf_q[`R_STAT][`ST_EV0_BIT] <= 1'b1;
         wb_ack_out <= wb_req;
         if (wb_req)
         begin
            if (wb_adr_in == `REG_CTRL_OFF)
               wb_dat_out <= {24'h000000, ctrl_q};
            else if (wb_adr_in == `REG_STATUS_OFF)
               wb_dat_out <= {24'h000000, stat};
            else if (wb_adr_in == `REG_PC_OFF)
               wb_dat_out <= {16'h0000, instruction_pointer_q};
            else if (wb_adr_in == `REG_EVT_OFF)
               wb_dat_out <= {30'h0, halted_out, zero_q};
            else if (wb_adr_in[7:6] == 2'b01)
               wb_dat_out <= {24'h000000, rf_q[wb_adr_in[5:2]]};
            else
               wb_dat_out <= 32'h00000000;
         end
      end
   end
endmodule // risc_core
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "core_consts.vh"
module tb_top;
   logic        clk_in;
   logic        rst_n_in;
   logic [15:0] prog_addr;
   logic [21:0] prog_data;
   logic [4:0]  src_q;
   logic        cyc_q;
   logic        stb_q;
   logic        we_q;
   logic [3:0]  sel_q;
   logic [7:0]  adr_q;
   logic [7:0]  rnd;
   logic [31:0] dat_q;
   logic [31:0] rd_dat;
   logic        ack;
   logic        halted;
   logic [7:0]  exp_q[$];
   int          err_total;
   int          checked;

   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   prog_rom prog_rom_inst (.addr_in(prog_addr), .rnd_in(rnd), .data_out(prog_data));
   risc_core risc_core_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .prog_addr_out(prog_addr),
      .prog_data_in(prog_data), .irq_low_in(src_q[0]), .irq_mid_in(src_q[1]), .irq_high_in(src_q[2]),
      .evt_low_in(src_q[3]), .evt_high_in(src_q[4]), .wb_cyc_in(cyc_q), .wb_stb_in(stb_q),
      .wb_we_in(we_q), .wb_adr_in(adr_q), .wb_dat_in(dat_q), .wb_sel_in(sel_q),
      .wb_dat_out(rd_dat), .wb_ack_out(ack), .halted_out(halted));

   task automatic bad(input string m);
      err_total++;
      $display("BAD %0t %s", $time, m);
   endtask

   task automatic print_verdict;
      $display("errors %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk_in);
      cyc_q <= 1'b1;
      stb_q <= 1'b1;
      we_q  <= w;
      adr_q <= a;
      dat_q <= {24'h0, d};
      n = 0;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         bad("no bus answer");
         print_verdict();
      end
      cyc_q <= 1'b0;
      stb_q <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 8'h00);
   endtask

   task automatic cmp_rd(input logic [31:0] got, input logic [7:0] e);
      checked++;
      if (got !== {24'h0, e})
         bad("read data differs");
   endtask

   // a zero-time pass also counts, so a stuck flag is still judged
   task automatic wait_halt(input logic v);
      int n;
      n = 0;
      while (halted !== v && n < 300)
      begin
         @(posedge clk_in);
         n++;
      end
      checked++;
      if (n >= 300)
      begin
         bad("run state wait ran out");
         print_verdict();
      end
   endtask

   task automatic pulse(input int b);
      @(posedge clk_in);
      src_q[b] <= 1'b1;
      @(posedge clk_in);
      src_q[b] <= 1'b0;
   endtask

   task automatic wake(input int b);
      pulse(b);
      wait_halt(1'b0);
      wait_halt(1'b1);
   endtask

   always @(posedge clk_in)
      if (ack === 1'b1 && we_q === 1'b0)
      begin
         if (exp_q.size() == 0)
            bad("read with no note");
         else
            cmp_rd(rd_dat, exp_q.pop_front());
      end

   initial
   begin
      rst_n_in  = 1'b0;
      cyc_q     = 1'b0;
      stb_q     = 1'b0;
      we_q      = 1'b0;
      sel_q     = 4'hf;
      adr_q     = 8'h00;
      dat_q     = 32'h0;
      src_q     = 5'h00;
      err_total = 0;
      checked   = 0;
      void'($urandom(32'hfbb7));
      rnd = 8'($urandom);
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(`REG_CTRL_OFF, `CTRL_RESET_VAL);
      rd(`REG_STATUS_OFF, `ST_RESET_VAL);
      rd(`REG_EVT_OFF, 8'h02);
      rd(8'h80, 8'h00);
      wb(1'b1, `REG_STATUS_OFF, 8'h05);
      wb(1'b1, `REG_CTRL_OFF, 8'h01);
      wait_halt(1'b0);
      wait_halt(1'b1);
      rd(`REG_FILE_OFF + 8'h04, rnd);
      wake(3);
      rd(`REG_FILE_OFF + 8'h08, 8'ha5);
      rd(`REG_STATUS_OFF, 8'h05);
      wake(0);
      rd(`REG_FILE_OFF + 8'h0c, 8'h33);
      rd(`REG_FILE_OFF + 8'h10, 8'h44);
      rd(`REG_STATUS_OFF, 8'h05);
      wb(1'b1, `REG_STATUS_OFF, 8'h04);
      pulse(0);
      pulse(1);
      repeat (30) @(posedge clk_in);
      wait_halt(1'b1);
      rd(`REG_STATUS_OFF, 8'h1c);
      wake(2);
      rd(`REG_FILE_OFF + 8'h14, 8'h55);
      rd(`REG_FILE_OFF + 8'h18, 8'h8f);
      rd(`REG_FILE_OFF + 8'h1c, 8'h77);
      rd(`REG_PC_OFF, 8'h39);
      rd(`REG_STATUS_OFF, 8'h00);
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
